// File: acg_defs.svh
`ifndef ACG_DEFS_SVH
`define ACG_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define ACG_OFF_MODULE_STOP 8'h00
`define ACG_OFF_PIN_SELECT 8'h04
`define ACG_OFF_SYNC_CONTROL 8'h08
`define ACG_OFF_CLOCK_CONFIG 8'h0C
`define ACG_OFF_CLOCK_ENABLE 8'h10
`define ACG_OFF_CLOCK_STATUS 8'h14
`define ACG_OFF_TRIGGER_ENABLE 8'h18
`define ACG_OFF_SCAN_CONTROL 8'h1C

// ==========================================================================
// Field positions
`define ACG_MSTP_CONV_BIT 0
`define ACG_MSTP_TIMER_BIT 1
`define ACG_CFG_SRC_BIT 0
`define ACG_CFG_DIV_LSB 4
`define ACG_CFG_DIV_MSB 7
`define ACG_EN_GATE_BIT 0
`define ACG_STAT_RUN_BIT 0
`define ACG_STAT_REFUSED_BIT 1
`define ACG_STAT_BUSY_BIT 2
`define ACG_SCAN_SW_TRIG_BIT 0
`define ACG_SCAN_FORCE_STOP_BIT 1

// ==========================================================================
// Reset values
`define ACG_MSTP_RST 2'h3
`define ACG_PIN_SEL_RST 8'h00
`define ACG_SYNC_DIS_RST 2'h0
`define ACG_SRC_RST 1'h0
`define ACG_DIV_RST 4'h0
`define ACG_TRIG_EN_RST 9'h000

// ==========================================================================
// Bus answers
`define ACG_RESP_OKAY 2'h0
`define ACG_RESP_SLVERR 2'h2

`endif

// File: acg_pkg.sv
// ==========================================================================
// Types
package acg_pkg;

	typedef enum logic [1:0] {
		GATE_CLOSED = 2'h0,
		GATE_OPEN = 2'h1,
		GATE_CLOSING = 2'h3
	} acg_gate_state_t;

	typedef struct packed {
		acg_gate_state_t state;
		logic [3:0] cnt;
		logic clk_out;
		logic timer_prev;
	} acg_gen_state_t;

	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [1:0] mstp;
		logic [7:0] pin_sel;
		logic [1:0] sync_dis;
		logic src_sel;
		logic [3:0] div;
		logic gate_en;
		logic cfg_refused;
		logic sync1;
		logic sync2;
		logic [8:0] trig_en;
		logic scan_start;
		logic force_stop;
	} acg_regs_t;

endpackage : acg_pkg

// File: acg_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Converter clock divider and glitch-free gate
module acg_clock_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic src_sel,
	input wire logic timer_clk_in,
	input wire logic [3:0] div,
	input wire logic gate_req,
	output logic conv_clk,
	output logic gate_open
);
	import acg_pkg::*;

	acg_gen_state_t q;
	acg_gen_state_t d;
	logic tick;
	logic [3:0] adv_cnt;
	logic adv_out;

	// The gate only opens or closes while the output is low, so the
	// converter never sees a shortened high phase.
	always_comb begin
		d = q;
		d.timer_prev = timer_clk_in;
		tick = src_sel ? (timer_clk_in && !q.timer_prev) : 1'b1;
		adv_cnt = q.cnt;
		adv_out = q.clk_out;
		if (tick) begin
			if (q.cnt == div) begin
				adv_cnt = 4'h0;
				adv_out = ~q.clk_out;
			end else begin
				adv_cnt = q.cnt + 4'h1;
			end
		end
		case (q.state)
			GATE_CLOSED: begin
				d.cnt = 4'h0;
				d.clk_out = 1'b0;
				if (gate_req) begin
					d.state = GATE_OPEN;
				end
			end
			GATE_OPEN: begin
				d.cnt = adv_cnt;
				d.clk_out = adv_out;
				if (!gate_req) begin
					d.state = GATE_CLOSING;
				end
			end
			GATE_CLOSING: begin
				if (gate_req) begin
					d.state = GATE_OPEN;
				end else if (!q.clk_out) begin // RULE_17
					d.state = GATE_CLOSED;
					d.cnt = 4'h0;
				end else begin
					d.cnt = adv_cnt;
					d.clk_out = adv_out;
				end
			end
			default: begin
				d.state = GATE_CLOSED;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{state: GATE_CLOSED, cnt: 4'h0, clk_out: 1'b0, timer_prev: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign conv_clk = q.clk_out;
	assign gate_open = (q.state != GATE_CLOSED);

endmodule : acg_clock_gen

`default_nettype wire

// File: acg_adc_clock_gate_sequencer.sv
// Contract
// RULE_01: Software releases converter stop before configuring.
// RULE_02: Software sets analog select on used pins.
// RULE_03: Synchronous operation is enabled after reset.
// RULE_04: Software disables sync per unit when unwanted.
// RULE_05: Pick source and divider, enable, await running.
// RULE_06: Release timer stop before using timer clock.
// RULE_07: Software waits stabilization before self-calibration.
// RULE_08: Self-calibration precedes any conversion.
// RULE_09: Software configures triggers per scan group.
// RULE_10: Software or enabled peripheral trigger starts scan.
// RULE_11: Software clears all nine trigger enables first.
// RULE_12: Software confirms converters idle before gating off.
// RULE_13: Clearing enable drops running flag once stopped.
// RULE_14: Clock settings change only while clock stopped.
// RULE_15: Setting enable raises running flag once supplied.
// RULE_16: Software retunes conversion timing after clock change.
// RULE_17: Glitch-free gate, status synchronised before reporting.
`include "acg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module acg_adc_clock_gate_sequencer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic timer_derived_clock,
	input wire logic [8:0] peripheral_trigger,
	input wire logic converter_busy,
	output logic converter_clock,
	output logic module_stop_control,
	output logic module_stop_control_e,
	output logic [7:0] analog_pin_select,
	output logic [1:0] sync_disable_unit,
	output logic scan_start,
	output logic force_stop
);
	import acg_pkg::*;

	acg_regs_t q;
	acg_regs_t d;
	logic [31:0] wv;
	logic gate_open;
	logic gate_req;
	logic timer_tick_in;
	logic periph_hit;
	logic sw_trig;

	// ======================================================================
	// Helpers
	function automatic logic [31:0] wmerge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : wmerge

	function automatic logic [31:0] rd_mux(
		input acg_regs_t r,
		input logic [7:0] addr,
		input logic busy
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			`ACG_OFF_MODULE_STOP: begin
				v[1:0] = r.mstp;
			end
			`ACG_OFF_PIN_SELECT: begin
				v[7:0] = r.pin_sel;
			end
			`ACG_OFF_SYNC_CONTROL: begin
				v[1:0] = r.sync_dis;
			end
			`ACG_OFF_CLOCK_CONFIG: begin
				v[`ACG_CFG_SRC_BIT] = r.src_sel;
				v[`ACG_CFG_DIV_MSB:`ACG_CFG_DIV_LSB] = r.div;
			end
			`ACG_OFF_CLOCK_ENABLE: begin
				v[`ACG_EN_GATE_BIT] = r.gate_en;
			end
			`ACG_OFF_CLOCK_STATUS: begin
				v[`ACG_STAT_RUN_BIT] = r.sync2;
				v[`ACG_STAT_REFUSED_BIT] = r.cfg_refused;
				v[`ACG_STAT_BUSY_BIT] = busy;
			end
			`ACG_OFF_TRIGGER_ENABLE: begin
				v[8:0] = r.trig_en;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction : rd_mux

	function automatic logic addr_mapped(input logic [7:0] addr);
		logic hit;
		hit = (addr[1:0] == 2'h0) && (addr <= `ACG_OFF_SCAN_CONTROL);
		return hit;
	endfunction : addr_mapped

	// ======================================================================
	// Clock generation and gate
	// A stopped timer module delivers no edges, so the timer source is
	// only live once its stop bit is released.
	assign timer_tick_in = timer_derived_clock & ~q.mstp[`ACG_MSTP_TIMER_BIT]; // RULE_06
	assign gate_req = q.gate_en & ~q.mstp[`ACG_MSTP_CONV_BIT]; // RULE_13

	acg_clock_gen u_clock_gen (
		.clk(clk),
		.rst_n(rst_n),
		.src_sel(q.src_sel),
		.timer_clk_in(timer_tick_in),
		.div(q.div),
		.gate_req(gate_req),
		.conv_clk(converter_clock),
		.gate_open(gate_open)
	);

	// ======================================================================
	// Triggers
	assign periph_hit = |(peripheral_trigger & q.trig_en);
	assign sw_trig = q.aw_full && q.w_full && !q.b_valid
		&& (q.aw_addr == `ACG_OFF_SCAN_CONTROL) && q.w_strb[0]
		&& q.w_data[`ACG_SCAN_SW_TRIG_BIT];

	// ======================================================================
	// Next state
	always_comb begin
		d = q;
		wv = 32'h0000_0000;
		d.scan_start = 1'b0;
		d.force_stop = 1'b0;
		d.sync1 = gate_open; // RULE_17
		d.sync2 = q.sync1; // RULE_17

		// Scans need a running clock and a released module.
		if ((sw_trig || periph_hit) && q.sync2 && !q.mstp[`ACG_MSTP_CONV_BIT]) begin
			d.scan_start = 1'b1; // RULE_10
		end

		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.b_valid && s_axi_bready) begin
			d.b_valid = 1'b0;
		end

		if (q.aw_full && q.w_full && !q.b_valid) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.b_valid = 1'b1;
			d.b_resp = `ACG_RESP_OKAY;
			case (q.aw_addr)
				`ACG_OFF_MODULE_STOP: begin
					wv = wmerge({30'h0000_0000, q.mstp}, q.w_data, q.w_strb);
					d.mstp = wv[1:0];
				end
				`ACG_OFF_PIN_SELECT: begin
					wv = wmerge({24'h00_0000, q.pin_sel}, q.w_data, q.w_strb);
					d.pin_sel = wv[7:0];
				end
				`ACG_OFF_SYNC_CONTROL: begin
					wv = wmerge({30'h0000_0000, q.sync_dis}, q.w_data, q.w_strb);
					d.sync_dis = wv[1:0];
				end
				`ACG_OFF_CLOCK_CONFIG: begin
					wv = wmerge(rd_mux(q, q.aw_addr, converter_busy), q.w_data, q.w_strb);
					// Switching source or ratio under a live gate could chop a
					// phase, so such writes are dropped and flagged instead.
					if (q.gate_en || q.sync2) begin
						d.cfg_refused = 1'b1; // RULE_14
					end else begin
						d.src_sel = wv[`ACG_CFG_SRC_BIT];
						d.div = wv[`ACG_CFG_DIV_MSB:`ACG_CFG_DIV_LSB];
					end
				end
				`ACG_OFF_CLOCK_ENABLE: begin
					wv = wmerge({31'h0000_0000, q.gate_en}, q.w_data, q.w_strb);
					d.gate_en = wv[`ACG_EN_GATE_BIT]; // RULE_15
				end
				`ACG_OFF_CLOCK_STATUS: begin
					wv = wmerge(32'h0000_0000, q.w_data, q.w_strb);
					d.cfg_refused = q.cfg_refused & ~wv[`ACG_STAT_REFUSED_BIT];
				end
				`ACG_OFF_TRIGGER_ENABLE: begin
					wv = wmerge({23'h00_0000, q.trig_en}, q.w_data, q.w_strb);
					d.trig_en = wv[8:0];
				end
				`ACG_OFF_SCAN_CONTROL: begin
					wv = wmerge(32'h0000_0000, q.w_data, q.w_strb);
					d.force_stop = wv[`ACG_SCAN_FORCE_STOP_BIT];
				end
				default: begin
					d.b_resp = `ACG_RESP_SLVERR;
				end
			endcase
		end

		if (s_axi_arvalid && s_axi_arready) begin
			d.r_valid = 1'b1;
			d.r_data = rd_mux(q, s_axi_araddr[7:0], converter_busy);
			d.r_resp = addr_mapped(s_axi_araddr[7:0]) ? `ACG_RESP_OKAY : `ACG_RESP_SLVERR;
		end else if (q.r_valid && s_axi_rready) begin
			d.r_valid = 1'b0;
		end
	end

	// ======================================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.mstp <= `ACG_MSTP_RST;
			q.pin_sel <= `ACG_PIN_SEL_RST;
			q.sync_dis <= `ACG_SYNC_DIS_RST; // RULE_03
			q.src_sel <= `ACG_SRC_RST;
			q.div <= `ACG_DIV_RST;
			q.trig_en <= `ACG_TRIG_EN_RST;
		end else begin
			q <= d;
		end
	end

	// ======================================================================
	// Outputs
	assign s_axi_awready = !q.aw_full && !q.b_valid;
	assign s_axi_wready = !q.w_full && !q.b_valid;
	assign s_axi_bvalid = q.b_valid;
	assign s_axi_bresp = q.b_resp;
	assign s_axi_arready = !q.r_valid;
	assign s_axi_rvalid = q.r_valid;
	assign s_axi_rdata = q.r_data;
	assign s_axi_rresp = q.r_resp;
	assign module_stop_control = q.mstp[`ACG_MSTP_CONV_BIT];
	assign module_stop_control_e = q.mstp[`ACG_MSTP_TIMER_BIT];
	assign analog_pin_select = q.pin_sel;
	assign sync_disable_unit = q.sync_dis;
	assign scan_start = q.scan_start;
	assign force_stop = q.force_stop;

endmodule : acg_adc_clock_gate_sequencer

`default_nettype wire

// File: acg_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Port checks
module acg_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic converter_clock,
	input wire logic module_stop_control,
	input wire logic [1:0] sync_disable_unit,
	input wire logic scan_start,
	input wire logic force_stop
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence gate_shut_s;
		(module_stop_control && !converter_clock) [*2];
	endsequence
	chk_sync_on_reset: assert property ($rose(rst_n) |-> sync_disable_unit == 2'h0)
		else $error("sync disabled after reset");
	chk_scan_needs_run: assert property (scan_start |-> $past(module_stop_control) == 1'h0)
		else $error("scan started while stopped");
	// Forty cycles cover the longest high phase of a divide by sixteen.
	chk_stop_gates: assert property ($rose(module_stop_control) |-> ##[1:40] !converter_clock)
		else $error("clock not gated after stop");
	chk_gate_stays: assert property (gate_shut_s |=> !converter_clock)
		else $error("gated clock rose");
	chk_force_on_b: assert property (force_stop |-> $rose(s_axi_bvalid))
		else $error("force stop off the write answer");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
endmodule : acg_chk
bind acg_adc_clock_gate_sequencer acg_chk u_chk (.*);
`default_nettype wire

// File: acg_adc_clock_gate_sequencer_tb.sv
`include "acg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// ========
// Bench
module acg_adc_clock_gate_sequencer_tb;
	import acg_pkg::*;
	localparam logic [7:0] MS = `ACG_OFF_MODULE_STOP;
	localparam logic [7:0] CF = `ACG_OFF_CLOCK_CONFIG;
	localparam logic [7:0] EN = `ACG_OFF_CLOCK_ENABLE;
	localparam logic [7:0] ST = `ACG_OFF_CLOCK_STATUS;
	localparam logic [7:0] TG = `ACG_OFF_TRIGGER_ENABLE;
	localparam logic [7:0] SC = `ACG_OFF_SCAN_CONTROL;
	logic clk = 0, rst_n = 0, timer_derived_clock = 0, converter_busy = 0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	// Response readies stay high: the bench never stalls an answer.
	logic s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, sync_disable_unit;
	logic [8:0] peripheral_trigger = '0, tg;
	logic converter_clock, module_stop_control, module_stop_control_e, scan_start, force_stop;
	logic [7:0] analog_pin_select, pin;
	logic [3:0] d;
	int bad_count = 0, tests_run = 0;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	bit sq[$];
	bit fq[$];
	acg_adc_clock_gate_sequencer dut (.*);
	always #5 clk = ~clk;
	always @(posedge clk) timer_derived_clock <= 1'($urandom);
	task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
		tests_run++;
		if (e !== g) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : cmp
	// Outputs are looked at on the falling edge, where they have settled and
	// still stand for the rising edge that completes the handshake.
	always @(negedge clk) begin
		if (s_axi_bvalid && s_axi_bready) cmp("bresp", bq.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready) cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (scan_start) cmp("scan_start", 1, sq.size() != 0);
		if (scan_start && sq.size() != 0) void'(sq.pop_front());
		if (force_stop) cmp("force_stop", 1, fq.size() != 0);
		if (force_stop && fq.size() != 0) void'(fq.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = 2'h0);
		logic at, wt, bt;
		bq.push_back(r);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(negedge clk);
			at = s_axi_awready;
			wt = s_axi_wready;
			bt = s_axi_bvalid;
			@(posedge clk);
			if (at) s_axi_awvalid <= 0;
			if (wt) s_axi_wvalid <= 0;
		end while (!bt);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		logic t;
		rq.push_back({r, e});
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1;
		do begin
			@(negedge clk);
			t = s_axi_arready;
			@(posedge clk);
		end while (!t);
		s_axi_arvalid <= 0;
		do begin
			@(negedge clk);
			t = s_axi_rvalid;
			@(posedge clk);
		end while (!t);
	endtask : rd
	task automatic per(input logic [3:0] v);
		realtime t;
		@(posedge converter_clock);
		t = $realtime;
		@(posedge converter_clock);
		cmp("period", 2 * (v + 1), int'(($realtime - t) / 10.0));
	endtask : per
	task automatic conclude;
		if (sq.size() != 0 || fq.size() != 0) bad_count++;
		if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	initial begin
		void'($urandom(32'h3d77_690d));
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rd(MS, 32'h3);
		rd(`ACG_OFF_SYNC_CONTROL, 0);
		rd(8'h20, 0, 2'h2);
		wr(8'h02, 32'hffff_ffff, 2'h2);
		wr(MS, 32'h2);
		cmp("module_stop_control", 0, module_stop_control);
		pin = 8'($urandom);
		wr(`ACG_OFF_PIN_SELECT, pin);
		cmp("analog_pin_select", pin, analog_pin_select);
		wr(`ACG_OFF_SYNC_CONTROL, 32'h3);
		cmp("sync_disable_unit", 2'h3, sync_disable_unit);
		d = 4'($urandom_range(3));
		wr(CF, d << 4);
		wr(EN, 32'h1);
		rd(ST, 0);
		rd(ST, 32'h1);
		per(d);
		wr(CF, 32'h00f0);
		rd(ST, 32'h3);
		rd(CF, d << 4);
		wr(ST, 32'h2);
		rd(ST, 32'h1);
		tg = 9'($urandom) | 9'h001;
		wr(TG, tg);
		for (int i = 0; i < 9; i++) begin
			peripheral_trigger <= 9'h001 << i;
			if (tg[i]) sq.push_back(1);
			@(posedge clk);
		end
		peripheral_trigger <= '0;
		sq.push_back(1);
		wr(SC, 32'h1);
		fq.push_back(1);
		wr(SC, 32'h2);
		wr(TG, 0);
		peripheral_trigger <= '1;
		converter_busy <= 1;
		rd(ST, 32'h5);
		peripheral_trigger <= '0;
		converter_busy <= 0;
		wr(EN, 0);
		repeat (40) @(posedge clk);
		rd(ST, 0);
		cmp("converter_clock", 0, converter_clock);
		wr(SC, 32'h1);
		wr(MS, 0);
		d = 4'($urandom_range(15, 4));
		wr(CF, d << 4);
		rd(CF, d << 4);
		wr(EN, 32'h1);
		rd(ST, 0);
		rd(ST, 32'h1);
		per(d);
		wr(MS, 32'h1);
		repeat (40) @(posedge clk);
		cmp("converter_clock", 0, converter_clock);
		wr(EN, 0);
		repeat (40) @(posedge clk);
		wr(MS, 0);
		wr(CF, 32'h1);
		rd(CF, 32'h1);
		wr(EN, 32'h1);
		rd(ST, 0);
		rd(ST, 32'h1);
		@(posedge converter_clock);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule : acg_adc_clock_gate_sequencer_tb
`default_nettype wire
